// ### sca_config_alarm.sv
// Configuration image, checksum gate, alarm and level-steering output stage
`timescale 1ns/1ps
// Summary of operation
// - On checksum failure the output shows the 10-bit fault value in bytes 40-41.
// - Low alarm asserts when selected source falls below byte 27.
// - High alarm asserts when selected source rises above byte 29.
// - Output code takes byte 28 during low alarm, byte 30 during high alarm.
// - Steering: bytes 27, 28, 29 set pin code steps 00-01, 01-10, 10-11.
// - Top three bits of byte 31 select one of six alarm sources.
// - Two bits of byte 31 select one of four steering sources; low nibble unused.
// - With alarm and steering both enabled, only steering runs.
// - Current and voltage mode both set disables the alarm.
// - Byte 24: upper nibble last pressure index, lower nibble last temperature index.
// - Ten-bit points and offsets sit right-justified in 12-bit fields.
// - Coarse byte: sign invert, temp amp gain, coarse offset, coarse gain.
// - Coarse gain above 3 selects 0-10 V range, otherwise 0-5 V.
// - Clock trim picks low, mid or high value by two temperature breakpoints.
// - Bytes 37-38 and 42-46 are stored for the user and never used.
// - Working RAM: mode at 0, locations 1-10 hold the low coefficient bytes.
// - Output code is 10-bit unsigned, 0 to 3FFh.
module sca_config_alarm (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic cfgWrEn,
    input wire logic [5:0] cfgWrAddr,
    input wire logic [7:0] cfgWrData,
    input wire logic [5:0] cfgRdAddr,
    output logic [7:0] cfgRdData,
    input wire logic imageLoaded,
    input wire logic [7:0] modeByte,
    input wire logic alarmEnable,
    input wire logic steerEnable,
    input wire logic currentOutputMode,
    input wire logic voltageOutputMode,
    input wire logic [9:0] temperatureSource,
    input wire logic [9:0] instAmpSource,
    input wire logic [9:0] gainStageSource,
    input wire logic [9:0] voltageOutputSource,
    input wire logic steerPinLowIn,
    input wire logic steerPinHighIn,
    input wire logic [9:0] conditionedCode,
    input wire logic [9:0] internalTemp,
    input wire logic [3:0] ramAddr,
    output logic [7:0] ramData,
    output logic [9:0] digitalOutputCode,
    output logic alarmLow,
    output logic alarmHigh,
    output logic steerPinLow,
    output logic steerPinHigh,
    output logic cfgReady,
    output logic checksumFail,
    output logic signalSignInvert,
    output logic [1:0] tempAmpGainSel,
    output logic [1:0] coarseSignalOffset,
    output logic [2:0] coarseSignalGain,
    output logic range10V,
    output logic [3:0] lastPressureIdx,
    output logic [3:0] lastTempIdx,
    output logic [3:0] tempFilterCoef,
    output logic [7:0] clockTrimValue,
    output logic [7:0] clockTrimAmpSetting
);
    typedef struct packed {
        logic [47:0][7:0] img;
        logic [7:0] rdData;
        logic [7:0] ramData;
        logic [9:0] code;
        logic alarmLow;
        logic alarmHigh;
        logic steerLow;
        logic steerHigh;
        logic ready;
        logic fail;
        logic signInv;
        logic [1:0] tGain;
        logic [1:0] csOfs;
        logic [2:0] csGain;
        logic range10V;
        logic [3:0] lastP;
        logic [3:0] lastT;
        logic [3:0] filt;
        logic [7:0] trim;
        logic [7:0] trimAmp;
    } sca_state_type;

    sca_state_type st_r;
    sca_state_type st_nxt;

    logic [5:0] ckIdx;
    logic ckBusy;
    logic ckDone;
    logic ckOk;
    logic [9:0] alarmSrc;
    logic [9:0] steerSrc;
    logic alarmSrcValid;
    logic aBelow;
    logic aAbove;
    logic [1:0] aLevel;
    logic sBelow;
    logic sAbove;
    logic [1:0] sLevel;
    logic alarmActive;
    logic [7:0] cfgByte31;

    // Unpacks a 10-bit value stored high-low across two bytes
    function automatic logic [9:0] unpack10(input logic [7:0] hi, input logic [7:0] lo);
        unpack10 = {hi[sca_pkg::FAULT_HIGH_BITS-1:0], lo};
    endfunction : unpack10

    // Expands an 8-bit alarm value to the 10-bit output code scale
    function automatic logic [9:0] expand8(input logic [7:0] b);
        expand8 = {b, 2'b00};
    endfunction : expand8

    sca_checksum u_checksum (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .start(imageLoaded),
        .byteIn(st_r.img[ckIdx]),
        .byteIdx(ckIdx),
        .busy(ckBusy),
        .done(ckDone),
        .ok(ckOk)
    );

    assign cfgByte31 = st_r.img[sca_pkg::OFS_ALARM_STEER_SELECT];

    always_comb begin
        alarmSrcValid = 1'b1;
        unique case (sca_pkg::sca_alarm_src_type'(cfgByte31[sca_pkg::ALARM_SEL_LSB +: 3]))
            sca_pkg::ASRC_TEMPERATURE: alarmSrc = temperatureSource;
            sca_pkg::ASRC_INST_AMP: alarmSrc = instAmpSource;
            sca_pkg::ASRC_GAIN_STAGE: alarmSrc = gainStageSource;
            sca_pkg::ASRC_VOLTAGE_OUT: alarmSrc = voltageOutputSource;
            sca_pkg::ASRC_STEER_PIN_LOW: alarmSrc = {10{steerPinLowIn}};
            sca_pkg::ASRC_STEER_PIN_HIGH: alarmSrc = {10{steerPinHighIn}};
            default: begin
                alarmSrc = sca_pkg::CODE_RESET;
                alarmSrcValid = 1'b0;
            end
        endcase
        unique case (sca_pkg::sca_steer_src_type'(cfgByte31[sca_pkg::STEER_SEL_LSB +: 2]))
            sca_pkg::SSRC_TEMPERATURE: steerSrc = temperatureSource;
            sca_pkg::SSRC_INST_AMP: steerSrc = instAmpSource;
            sca_pkg::SSRC_GAIN_STAGE: steerSrc = gainStageSource;
            sca_pkg::SSRC_VOLTAGE_OUT: steerSrc = voltageOutputSource;
        endcase
    end

    sca_level_cmp u_alarm_cmp (
        .src(alarmSrc),
        .thrA(st_r.img[sca_pkg::OFS_ALARM_LOW_THRESHOLD]),
        .thrB(st_r.img[sca_pkg::OFS_ALARM_LOW_OUTPUT]),
        .thrC(st_r.img[sca_pkg::OFS_ALARM_HIGH_THRESHOLD]),
        .below(aBelow),
        .above(aAbove),
        .level(aLevel)
    );

    sca_level_cmp u_steer_cmp (
        .src(steerSrc),
        .thrA(st_r.img[sca_pkg::OFS_ALARM_LOW_THRESHOLD]),
        .thrB(st_r.img[sca_pkg::OFS_ALARM_LOW_OUTPUT]),
        .thrC(st_r.img[sca_pkg::OFS_ALARM_HIGH_THRESHOLD]),
        .below(sBelow),
        .above(sAbove),
        .level(sLevel)
    );

    // Steering wins over alarm; direct digital mode kills the alarm
    assign alarmActive = alarmEnable && !steerEnable
        && !(currentOutputMode && voltageOutputMode) && alarmSrcValid;

    always_comb begin
        st_nxt = st_r;
        if (cfgWrEn && (cfgWrAddr <= sca_pkg::LAST_BYTE)) begin
            st_nxt.img[cfgWrAddr] = cfgWrData;
        end
        if (cfgRdAddr <= sca_pkg::LAST_BYTE) begin
            st_nxt.rdData = st_r.img[cfgRdAddr];
        end else begin
            st_nxt.rdData = sca_pkg::BYTE_RESET;
        end
        // RAM location n (1..10) mirrors image byte n+2
        if (ramAddr == sca_pkg::RAM_MODE_LOC) begin
            st_nxt.ramData = modeByte;
        end else if (ramAddr <= sca_pkg::RAM_LAST_LOW_LOC) begin
            st_nxt.ramData = st_r.img[sca_pkg::OFS_FIXED_GAIN_LOW_BYTE + {2'b00, ramAddr} - 6'h01];
        end else begin
            st_nxt.ramData = sca_pkg::BYTE_RESET;
        end
        if (imageLoaded) begin
            st_nxt.ready = 1'b0;
        end else if (ckDone) begin
            st_nxt.ready = 1'b1;
            st_nxt.fail = !ckOk;
        end
        {st_nxt.signInv, st_nxt.tGain, st_nxt.csOfs, st_nxt.csGain} =
            st_r.img[sca_pkg::OFS_COARSE_AMP_CONTROL];
        st_nxt.range10V = (st_r.img[sca_pkg::OFS_COARSE_AMP_CONTROL][2:0]
            > sca_pkg::COARSE_GAIN_5V_MAX);
        st_nxt.lastP = st_r.img[sca_pkg::OFS_GAP_COUNT_INDICES][sca_pkg::GAP_PRESSURE_LSB +: 4];
        st_nxt.lastT = st_r.img[sca_pkg::OFS_GAP_COUNT_INDICES][sca_pkg::GAP_TEMP_LSB +: 4];
        st_nxt.filt = st_r.img[sca_pkg::OFS_TEMP_FILTER_COEF][3:0];
        st_nxt.trimAmp = st_r.img[sca_pkg::OFS_CLOCK_TRIM_AMP_SETTING];
        if (internalTemp[9:2] < st_r.img[sca_pkg::OFS_CLOCK_TRIM_BREAKPOINT_A]) begin
            st_nxt.trim = st_r.img[sca_pkg::OFS_CLOCK_TRIM_LOW_TEMP];
        end else if (internalTemp[9:2] < st_r.img[sca_pkg::OFS_CLOCK_TRIM_BREAKPOINT_B]) begin
            st_nxt.trim = st_r.img[sca_pkg::OFS_CLOCK_TRIM_MID_TEMP];
        end else begin
            st_nxt.trim = st_r.img[sca_pkg::OFS_CLOCK_TRIM_HIGH_TEMP];
        end
        st_nxt.alarmLow = 1'b0;
        st_nxt.alarmHigh = 1'b0;
        st_nxt.steerLow = 1'b0;
        st_nxt.steerHigh = 1'b0;
        if (!st_r.ready) begin
            st_nxt.code = sca_pkg::CODE_RESET;
        end else if (st_r.fail) begin
            st_nxt.code = unpack10(st_r.img[sca_pkg::OFS_FAULT_OUTPUT_VALUE],
                st_r.img[sca_pkg::OFS_FAULT_OUTPUT_VALUE + 6'h01]);
        end else begin
            st_nxt.code = conditionedCode;
            if (steerEnable) begin
                {st_nxt.steerHigh, st_nxt.steerLow} = sLevel;
            end else if (alarmActive && aBelow) begin
                st_nxt.alarmLow = 1'b1;
                st_nxt.code = expand8(st_r.img[sca_pkg::OFS_ALARM_LOW_OUTPUT]);
            end else if (alarmActive && aAbove) begin
                st_nxt.alarmHigh = 1'b1;
                st_nxt.code = expand8(st_r.img[sca_pkg::OFS_ALARM_HIGH_OUTPUT]);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign cfgRdData = st_r.rdData;
    assign ramData = st_r.ramData;
    assign digitalOutputCode = st_r.code;
    assign alarmLow = st_r.alarmLow;
    assign alarmHigh = st_r.alarmHigh;
    assign steerPinLow = st_r.steerLow;
    assign steerPinHigh = st_r.steerHigh;
    assign cfgReady = st_r.ready;
    assign checksumFail = st_r.fail;
    assign signalSignInvert = st_r.signInv;
    assign tempAmpGainSel = st_r.tGain;
    assign coarseSignalOffset = st_r.csOfs;
    assign coarseSignalGain = st_r.csGain;
    assign range10V = st_r.range10V;
    assign lastPressureIdx = st_r.lastP;
    assign lastTempIdx = st_r.lastT;
    assign tempFilterCoef = st_r.filt;
    assign clockTrimValue = st_r.trim;
    assign clockTrimAmpSetting = st_r.trimAmp;

    sequence s_loadReq;
        clkEn && imageLoaded;
    endsequence

    sequence s_checkDone;
        clkEn && ckDone;
    endsequence

    property p_check_time;
        @(posedge ref_clk) disable iff (!rst_b)
        s_loadReq |-> ##[48:300] s_checkDone;
    endproperty
    a_check_time: assert property (p_check_time) else $error("checksum walk did not finish");

    property p_fault;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && st_r.ready && st_r.fail |=> digitalOutputCode ==
            {$past(st_r.img[sca_pkg::OFS_FAULT_OUTPUT_VALUE][1:0]),
            $past(st_r.img[sca_pkg::OFS_FAULT_OUTPUT_VALUE + 6'h01])};
    endproperty
    a_fault: assert property (p_fault) else $error("fault value not on output");

    property p_alarm_low;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && st_r.ready && !st_r.fail && alarmActive && aBelow |=> alarmLow && !alarmHigh;
    endproperty
    a_alarm_low: assert property (p_alarm_low) else $error("low alarm missed");

    property p_alarm_high;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && st_r.ready && !st_r.fail && alarmActive && !aBelow && aAbove |=> alarmHigh;
    endproperty
    a_alarm_high: assert property (p_alarm_high) else $error("high alarm missed");

    property p_low_value;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && alarmLow |-> digitalOutputCode ==
            {$past(st_r.img[sca_pkg::OFS_ALARM_LOW_OUTPUT]), 2'b00}
            && !steerPinLow && !steerPinHigh;
    endproperty
    a_low_value: assert property (p_low_value) else $error("alarm code scale wrong");

    property p_steer_dominant;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && steerEnable |=> !alarmLow && !alarmHigh;
    endproperty
    a_steer_dominant: assert property (p_steer_dominant) else $error("alarm ran with steering");

    property p_digital_mode;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && currentOutputMode && voltageOutputMode |=> !alarmLow && !alarmHigh;
    endproperty
    a_digital_mode: assert property (p_digital_mode) else $error("alarm in digital mode");

    property p_range;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn |=> range10V ==
            ($past(st_r.img[sca_pkg::OFS_COARSE_AMP_CONTROL][2:0]) > sca_pkg::COARSE_GAIN_5V_MAX);
    endproperty
    a_range: assert property (p_range) else $error("output range wrong");

    property p_gap;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn |=> {lastPressureIdx, lastTempIdx} ==
            $past(st_r.img[sca_pkg::OFS_GAP_COUNT_INDICES]);
    endproperty
    a_gap: assert property (p_gap) else $error("gap indices wrong");

    property p_not_ready;
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && imageLoaded |=> !cfgReady ##1 (digitalOutputCode == sca_pkg::CODE_RESET || !clkEn);
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("output before check");
endmodule : sca_config_alarm

// ### sca_pkg.sv
// Constants for the configuration image, alarm and level-steering block
package sca_pkg;
    localparam int IMAGE_BYTES = 48;
    localparam int ADDR_W = 6;
    localparam logic [5:0] LAST_BYTE = 6'h2F;
    localparam logic [7:0] CHECKSUM_TARGET = 8'hFF;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [9:0] CODE_RESET = 10'h000;

    // Byte offsets in the configuration image
    localparam logic [5:0] OFS_COARSE_AMP_CONTROL = 6'h02;
    localparam logic [5:0] OFS_FIXED_GAIN_LOW_BYTE = 6'h03;
    localparam logic [5:0] OFS_GAP_COUNT_INDICES = 6'h18;
    localparam logic [5:0] OFS_TEMP_FILTER_COEF = 6'h19;
    localparam logic [5:0] OFS_ALARM_LOW_THRESHOLD = 6'h1B;
    localparam logic [5:0] OFS_ALARM_LOW_OUTPUT = 6'h1C;
    localparam logic [5:0] OFS_ALARM_HIGH_THRESHOLD = 6'h1D;
    localparam logic [5:0] OFS_ALARM_HIGH_OUTPUT = 6'h1E;
    localparam logic [5:0] OFS_ALARM_STEER_SELECT = 6'h1F;
    localparam logic [5:0] OFS_CLOCK_TRIM_LOW_TEMP = 6'h20;
    localparam logic [5:0] OFS_CLOCK_TRIM_MID_TEMP = 6'h21;
    localparam logic [5:0] OFS_CLOCK_TRIM_HIGH_TEMP = 6'h22;
    localparam logic [5:0] OFS_CLOCK_TRIM_BREAKPOINT_A = 6'h23;
    localparam logic [5:0] OFS_CLOCK_TRIM_BREAKPOINT_B = 6'h24;
    localparam logic [5:0] OFS_CLOCK_TRIM_AMP_SETTING = 6'h27;
    localparam logic [5:0] OFS_FAULT_OUTPUT_VALUE = 6'h28;
    localparam logic [5:0] OFS_IMAGE_CHECKSUM = 6'h2F;

    // Working-copy RAM map
    localparam logic [3:0] RAM_MODE_LOC = 4'h0;
    localparam logic [3:0] RAM_LAST_LOW_LOC = 4'hA;

    // Field positions
    localparam int COARSE_SIGN_BIT = 7;
    localparam int COARSE_TGAIN_LSB = 5;
    localparam int COARSE_OFS_LSB = 3;
    localparam int COARSE_GAIN_LSB = 0;
    localparam logic [2:0] COARSE_GAIN_5V_MAX = 3'h3;
    localparam int GAP_PRESSURE_LSB = 4;
    localparam int GAP_TEMP_LSB = 0;
    localparam int ALARM_SEL_LSB = 5;
    localparam int STEER_SEL_LSB = 5;
    localparam int FAULT_HIGH_BITS = 2;

    typedef enum logic [2:0] {
        ASRC_TEMPERATURE = 3'b000,
        ASRC_INST_AMP = 3'b001,
        ASRC_GAIN_STAGE = 3'b010,
        ASRC_VOLTAGE_OUT = 3'b011,
        ASRC_STEER_PIN_LOW = 3'b100,
        ASRC_STEER_PIN_HIGH = 3'b101
    } sca_alarm_src_type;

    typedef enum logic [1:0] {
        SSRC_TEMPERATURE = 2'b00,
        SSRC_INST_AMP = 2'b01,
        SSRC_GAIN_STAGE = 2'b10,
        SSRC_VOLTAGE_OUT = 2'b11
    } sca_steer_src_type;
endpackage : sca_pkg

// ### sca_checksum.sv
// Walks the configuration image and checks that its bytes sum to the target
`timescale 1ns/1ps
module sca_checksum (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic start,
    input wire logic [7:0] byteIn,
    output logic [5:0] byteIdx,
    output logic busy,
    output logic done,
    output logic ok
);
    typedef struct packed {
        logic busy;
        logic [5:0] idx;
        logic [7:0] sum;
        logic done;
        logic ok;
    } sca_ck_state_type;

    sca_ck_state_type st_r;
    sca_ck_state_type st_nxt;
    logic [7:0] sumNow;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        sumNow = st_r.sum + byteIn;
        if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.idx = '0;
            st_nxt.sum = '0;
        end else if (st_r.busy) begin
            st_nxt.sum = sumNow;
            if (st_r.idx == sca_pkg::LAST_BYTE) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.ok = (sumNow == sca_pkg::CHECKSUM_TARGET);
            end else begin
                st_nxt.idx = st_r.idx + 6'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign byteIdx = st_r.idx;
    assign busy = st_r.busy;
    assign done = st_r.done;
    assign ok = st_r.ok;
endmodule : sca_checksum

// ### sca_level_cmp.sv
// Compares a source against three ascending byte thresholds
`timescale 1ns/1ps
module sca_level_cmp (
    input wire logic [9:0] src,
    input wire logic [7:0] thrA,
    input wire logic [7:0] thrB,
    input wire logic [7:0] thrC,
    output logic below,
    output logic above,
    output logic [1:0] level
);
    logic [7:0] srcTop;

    always_comb begin
        srcTop = src[9:2];
        below = (srcTop < thrA);
        above = (srcTop > thrC);
        if (srcTop < thrA) begin
            level = 2'h0;
        end else if (srcTop < thrB) begin
            level = 2'h1;
        end else if (srcTop < thrC) begin
            level = 2'h2;
        end else begin
            level = 2'h3;
        end
    end
endmodule : sca_level_cmp

// ### tb_top.sv
// Self-checking bench for the configuration image, alarm and level-steering block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    logic ref_clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, cfgWrEn = 1'b0, imageLoaded = 1'b0;
    logic [5:0] cfgWrAddr = 6'h00, cfgRdAddr = 6'h00;
    logic [7:0] cfgWrData = 8'h00, modeByte = 8'hA5, cfgRdData, ramData, clockTrimValue;
    logic alarmEnable = 1'b0, steerEnable = 1'b0, current_output_mode = 1'b0, voltage_output_mode = 1'b0;
    logic [9:0] tSrc = 10'h200, iSrc = 10'h200, gSrc = 10'h200, vSrc = 10'h200;
    logic pinLoIn = 1'b0, pinHiIn = 1'b0;
    logic [9:0] conditionedCode = 10'h155, internalTemp = 10'h000, digitalOutputCode;
    logic [3:0] ramAddr = 4'h0, lastPressureIdx, lastTempIdx, tempFilterCoef;
    logic alarmLow, alarmHigh, steerPinLow, steerPinHigh, cfgReady, checksumFail;
    logic signalSignInvert, range10V;
    logic [1:0] tempAmpGainSel, coarseSignalOffset;
    logic [2:0] coarseSignalGain;
    logic [7:0] clockTrimAmpSetting;
    logic [7:0] img [48];
    int n_errors = 0, cmp_count = 0;

    sca_config_alarm i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn),
        .cfgWrEn(cfgWrEn), .cfgWrAddr(cfgWrAddr), .cfgWrData(cfgWrData),
        .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData), .imageLoaded(imageLoaded),
        .modeByte(modeByte), .alarmEnable(alarmEnable), .steerEnable(steerEnable),
        .currentOutputMode(current_output_mode), .voltageOutputMode(voltage_output_mode), .temperatureSource(tSrc),
        .instAmpSource(iSrc), .gainStageSource(gSrc), .voltageOutputSource(vSrc),
        .steerPinLowIn(pinLoIn), .steerPinHighIn(pinHiIn), .conditionedCode(conditionedCode),
        .internalTemp(internalTemp), .ramAddr(ramAddr), .ramData(ramData),
        .digitalOutputCode(digitalOutputCode), .alarmLow(alarmLow), .alarmHigh(alarmHigh),
        .steerPinLow(steerPinLow), .steerPinHigh(steerPinHigh), .cfgReady(cfgReady),
        .checksumFail(checksumFail), .signalSignInvert(signalSignInvert),
        .tempAmpGainSel(tempAmpGainSel), .coarseSignalOffset(coarseSignalOffset),
        .coarseSignalGain(coarseSignalGain), .range10V(range10V),
        .lastPressureIdx(lastPressureIdx), .lastTempIdx(lastTempIdx),
        .tempFilterCoef(tempFilterCoef), .clockTrimValue(clockTrimValue),
        .clockTrimAmpSetting(clockTrimAmpSetting));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cfgWrEn <= 1'b1;
        cfgWrAddr <= a;
        cfgWrData <= d;
    endtask : wr

    task automatic wr_one(input logic [5:0] a, input logic [7:0] d);
        wr(a, d);
        @(posedge ref_clk);
        cfgWrEn <= 1'b0;
        settle();
    endtask : wr_one

    // Host fills the checksum byte, optionally spoiled by one
    task automatic load_image(input logic spoil);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 47; i++) s = s + img[i];
        img[47] = 8'hFF - s + {7'h00, spoil};
        for (int i = 0; i < 48; i++) wr(i[5:0], img[i]);
        @(posedge ref_clk);
        cfgWrEn <= 1'b0;
        imageLoaded <= 1'b1;
        @(posedge ref_clk);
        imageLoaded <= 1'b0;
        #1;
        `CHK("cfgReady drop", 1'b0, cfgReady)
        for (int n = 0; n < 70; n++) begin
            @(posedge ref_clk);
            #1;
            if (cfgReady === 1'b1) break;
            if (n == 69) begin
                n_errors++;
                tally_and_finish();
            end
        end
        settle();
        `CHK("checksumFail", spoil, checksumFail)
    endtask : load_image

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] ex);
        @(posedge ref_clk);
        cfgRdAddr <= a;
        settle();
        `CHK("cfgRdData", ex, cfgRdData)
    endtask : rd_chk

    task automatic fault_case;
        img[40] = 8'h02;
        img[41] = 8'h5A;
        load_image(1'b1);
        `CHK("fault code", 10'h25A, digitalOutputCode)
    endtask : fault_case

    task automatic fields_case;
        `CHK("sign", 1'b1, signalSignInvert)
        `CHK("tgain", 2'h2, tempAmpGainSel)
        `CHK("cofs", 2'h1, coarseSignalOffset)
        `CHK("cgain", 3'h5, coarseSignalGain)
        `CHK("range10", 1'b1, range10V)
        `CHK("lastP", 4'h5, lastPressureIdx)
        `CHK("lastT", 4'hA, lastTempIdx)
        `CHK("coef", 4'h7, tempFilterCoef)
        `CHK("ampSet", 8'h5C, clockTrimAmpSetting)
        rd_chk(6'h25, 8'h3C);
        rd_chk(6'h2A, 8'hC3);
        wr_one(6'h30, 8'h77);
        rd_chk(6'h30, 8'h00);
        // A write while the clock enable is low must leave the image untouched
        @(posedge ref_clk);
        clkEn <= 1'b0;
        wr_one(6'h25, 8'h00);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        rd_chk(6'h25, 8'h3C);
        wr_one(6'h02, 8'h4B);
        `CHK("range5", 1'b0, range10V)
        `CHK("cgain3", 3'h3, coarseSignalGain)
    endtask : fields_case

    task automatic trim_case(input logic [9:0] t, input logic [7:0] ex);
        @(posedge ref_clk);
        internalTemp <= t;
        settle();
        `CHK("clockTrim", ex, clockTrimValue)
    endtask : trim_case

    task automatic ram_case(input logic [3:0] a, input logic [7:0] ex);
        @(posedge ref_clk);
        ramAddr <= a;
        settle();
        `CHK("ramData", ex, ramData)
    endtask : ram_case

    // Drives the chosen alarm source low or high, the other analog sources mid-scale, the low pin input 1 and the high pin input 0
    task automatic alarm_case(input logic [2:0] sel, input logic [9:0] v, input logic lo,
                              input logic hi, input logic [9:0] code);
        wr_one(6'h1F, {sel, 5'h00});
        @(posedge ref_clk);
        tSrc <= (sel == 3'h0) ? v : 10'h200;
        iSrc <= (sel == 3'h1) ? v : 10'h200;
        gSrc <= (sel == 3'h2) ? v : 10'h200;
        vSrc <= (sel == 3'h3) ? v : 10'h200;
        pinLoIn <= (sel == 3'h4) ? v[9] : 1'b1;
        pinHiIn <= (sel == 3'h5) ? v[9] : 1'b0;
        settle();
        `CHK("alarmLow", lo, alarmLow)
        `CHK("alarmHigh", hi, alarmHigh)
        `CHK("alarm code", code, digitalOutputCode)
    endtask : alarm_case

    task automatic steer_case(input logic [7:0] sel, input logic [9:0] v, input logic [1:0] lv);
        wr_one(6'h1F, sel);
        @(posedge ref_clk);
        tSrc <= (sel == 8'h00) ? v : 10'h000;
        iSrc <= (sel == 8'h20) ? v : 10'h000;
        settle();
        `CHK("steer level", lv, {steerPinHigh, steerPinLow})
        `CHK("steer no alarm", 2'b00, {alarmHigh, alarmLow})
        `CHK("steer code", 10'h155, digitalOutputCode)
    endtask : steer_case

    initial begin
        for (int i = 0; i < 48; i++) img[i] = 8'h00;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        settle();
        `CHK("reset code", 10'h000, digitalOutputCode)
        `CHK("reset ready", 1'b0, cfgReady)
        img[2] = 8'hCD;
        img[3] = 8'h31;
        img[12] = 8'h3A;
        img[24] = 8'h5A;
        img[25] = 8'h07;
        img[27] = 8'h40;
        img[28] = 8'h80;
        img[29] = 8'hC0;
        img[30] = 8'hEE;
        img[32] = 8'h11;
        img[33] = 8'h22;
        img[34] = 8'h33;
        img[35] = 8'h40;
        img[36] = 8'h80;
        img[37] = 8'h3C;
        img[39] = 8'h5C;
        img[42] = 8'hC3;
        fault_case();
        load_image(1'b0);
        `CHK("normal code", 10'h155, digitalOutputCode)
        fields_case();
        trim_case(10'h0FC, 8'h11);
        trim_case(10'h100, 8'h22);
        trim_case(10'h200, 8'h33);
        ram_case(4'h0, 8'hA5);
        ram_case(4'h1, 8'h31);
        ram_case(4'hA, 8'h3A);
        ram_case(4'hB, 8'h00);
        @(posedge ref_clk);
        alarmEnable <= 1'b1;
        for (int s = 0; s < 4; s++) alarm_case(s[2:0], 10'h0FC, 1'b1, 1'b0, 10'h200);
        alarm_case(3'h0, 10'h100, 1'b0, 1'b0, 10'h155);
        alarm_case(3'h1, 10'h300, 1'b0, 1'b0, 10'h155);
        alarm_case(3'h2, 10'h304, 1'b0, 1'b1, 10'h3B8);
        alarm_case(3'h4, 10'h000, 1'b1, 1'b0, 10'h200);
        alarm_case(3'h5, 10'h3FF, 1'b0, 1'b1, 10'h3B8);
        alarm_case(3'h6, 10'h000, 1'b0, 1'b0, 10'h155);
        @(posedge ref_clk);
        current_output_mode <= 1'b1;
        alarm_case(3'h0, 10'h0FC, 1'b1, 1'b0, 10'h200);
        @(posedge ref_clk);
        voltage_output_mode <= 1'b1;
        alarm_case(3'h0, 10'h0FC, 1'b0, 1'b0, 10'h155);
        @(posedge ref_clk);
        current_output_mode <= 1'b0;
        voltage_output_mode <= 1'b0;
        steerEnable <= 1'b1;
        steer_case(8'h00, 10'h0FC, 2'b00);
        steer_case(8'h00, 10'h100, 2'b01);
        steer_case(8'h00, 10'h200, 2'b10);
        steer_case(8'h00, 10'h300, 2'b11);
        steer_case(8'h20, 10'h2FF, 2'b10);
        tally_and_finish();
    end
endmodule : tb_top
